/* File: hdl/fsr_pkg.sv */
// constants for the flash status register bank
package fsr_pkg;

   // clock rate and busy times
   localparam int unsigned CLK_MHZ     = 50;
   localparam int unsigned T_WRSR_US   = 2000;
   localparam int unsigned T_PROG_US   = 400;
   localparam int unsigned T_SERASE_US = 50000;
   localparam int unsigned T_BERASE_US = 200000;
   localparam int unsigned T_CERASE_US = 8000000;
   localparam int unsigned WRSR_CYC_DEF   = T_WRSR_US * CLK_MHZ;
   localparam int unsigned PROG_CYC_DEF   = T_PROG_US * CLK_MHZ;
   localparam int unsigned SERASE_CYC_DEF = T_SERASE_US * CLK_MHZ;
   localparam int unsigned BERASE_CYC_DEF = T_BERASE_US * CLK_MHZ;
   localparam int unsigned CERASE_CYC_DEF = T_CERASE_US * CLK_MHZ;

   // instruction codes
   localparam logic [7:0] CMD_WREN    = 8'h06;
   localparam logic [7:0] CMD_WRDI    = 8'h04;
   localparam logic [7:0] CMD_VWREN   = 8'h50;
   localparam logic [7:0] CMD_RDSR1   = 8'h05;
   localparam logic [7:0] CMD_RDSR2   = 8'h35;
   localparam logic [7:0] CMD_RDSR3   = 8'h15;
   localparam logic [7:0] CMD_WRSR1   = 8'h01;
   localparam logic [7:0] CMD_WRSR2   = 8'h31;
   localparam logic [7:0] CMD_WRSR3   = 8'h11;
   localparam logic [7:0] CMD_PROG    = 8'h02;
   localparam logic [7:0] CMD_SERASE  = 8'h20;
   localparam logic [7:0] CMD_BERASE  = 8'hd8;
   localparam logic [7:0] CMD_CERASE  = 8'hc7;
   localparam logic [7:0] CMD_SUSPEND = 8'h75;
   localparam logic [7:0] CMD_RESUME  = 8'h7a;
   localparam logic [7:0] CMD_RSTEN   = 8'h66;
   localparam logic [7:0] CMD_RST     = 8'h99;

   // minimum whole bytes in a frame per instruction, and the byte counter ceiling
   localparam logic [2:0] BYTES_ONE   = 3'h1;
   localparam logic [2:0] BYTES_WRSR  = 3'h2;
   localparam logic [2:0] BYTES_WRSR2 = 3'h3;
   localparam logic [2:0] BYTES_ERASE = 3'h4;
   localparam logic [2:0] BYTES_PROG  = 3'h5;
   localparam logic [2:0] BYTES_MAX   = 3'h7;

   // first register fields
   localparam int unsigned SR1_BUSY  = 0;
   localparam int unsigned SR1_WEL   = 1;
   localparam int unsigned SR1_RANGE = 2;
   localparam int unsigned SR1_TB    = 5;
   localparam int unsigned SR1_SEC   = 6;
   localparam int unsigned SR1_GUARD = 7;
   // second register fields
   localparam int unsigned SR2_QE    = 1;
   localparam int unsigned SR2_LB1   = 3;
   localparam int unsigned SR2_CMP   = 6;
   localparam int unsigned SR2_PAUSE = 7;
   // third register fields
   localparam int unsigned SR3_HFM   = 4;
   localparam int unsigned SR3_DRV   = 5;
   localparam int unsigned SR3_HOLD_OR_RESET_SELECT  = 7;

   // reset values
   localparam logic [5:0] SR1_CFG_RST = 6'h00;
   localparam logic [2:0] LB_RST      = 3'h0;
   localparam logic [1:0] DRV_RST     = 2'h0;
   localparam logic [7:0] BYTE_ZERO   = 8'h00;

   // pin sampler bit positions and idle levels
   localparam int unsigned PIN_CS   = 0;
   localparam int unsigned PIN_SCLK = 1;
   localparam int unsigned PIN_MOSI = 2;
   localparam int unsigned PIN_WP   = 3;
   localparam int unsigned PIN_HOLD = 4;
   localparam logic [4:0]  PIN_IDLE = 5'h19;

   // array geometry for protection
   localparam int unsigned ARRAY_AW      = 21;
   localparam logic [4:0]  SEC_BASE_BITS = 5'h0c;
   localparam logic [4:0]  SEC_MAX_BITS  = 5'h0f;
   localparam logic [4:0]  BLK_BASE_BITS = 5'h10;
   localparam logic [2:0]  SEC_SAT_RANGE = 3'h5;
   localparam logic [2:0]  BLK_ALL_RANGE = 3'h6;

   typedef enum logic [2:0] {
      OP_IDLE  = 3'b001,
      OP_WRSR  = 3'b010,
      OP_ARRAY = 3'b100
   } fsr_op_e;

endpackage

/* File: hdl/fsr_prot_chk.sv */
// array protection decode for one address
`timescale 1ns/1ps
`default_nettype none
module fsr_prot_chk #(
   parameter int unsigned AW = fsr_pkg::ARRAY_AW
) (
   input  wire logic [AW-1:0] addr,
   input  wire logic [2:0]    range,
   input  wire logic          from_low,
   input  wire logic          granule,
   input  wire logic          invert,
   output logic               hit,
   output logic               any
);
   import fsr_pkg::*;

   logic [4:0]    size_bits;
   logic          full;
   logic [AW-1:0] mask;
   logic          in_rgn;

   always_comb begin
      full      = 1'b0;
      size_bits = SEC_BASE_BITS;
      if (granule) begin
         // R18
         if (range >= SEC_SAT_RANGE) begin
            size_bits = SEC_MAX_BITS;
         end else begin
            size_bits = 5'(SEC_BASE_BITS + {2'h0, range} - 5'h01);
         end
      end else begin
         if (range >= BLK_ALL_RANGE) begin
            full = 1'b1;
         end else begin
            size_bits = 5'(BLK_BASE_BITS + {2'h0, range} - 5'h01);
         end
      end
      mask   = {AW{1'b1}} << size_bits;
      // R16
      in_rgn = from_low ? ((addr & mask) == '0) : ((addr & mask) == mask);
      // R2 R15
      hit    = ((range != 3'h0) & (full | in_rgn)) ^ invert;
      any    = invert ? !full : (range != 3'h0);
   end
endmodule
`default_nettype wire

/* File: hdl/fsr_bank.sv */
// status and configuration register bank behind the serial pins
// How it works
// R1 - bit seven of second: suspended flag
// R2 - invert bit flips protected and open regions
// R3 - three one-time lock bits, set only
// R4 - host ignores reserved bits when reading
// R5 - four-lane bit disables guard and pause pins
// R6 - third bit seven picks pause or reset
// R7 - volatile two-bit drive strength, default zero
// R8 - fast clock mode bit, two copies
// R9 - busy set during program, erase, writes
// R10 - busy ignores all but status reads and suspend
// R11 - busy clears when operation finishes
// R12 - write enable sets write arm latch
// R13 - arm latch cleared by disable, writes, reset
// R14 - three range bits, written by status write
// R15 - reject program or erase in protected range
// R16 - low end bit counts range from bottom
// R17 - low end bit write needs guard, latch
// R18 - granule bit picks sectors or blocks
// R19 - arm then write updates persistent copies
// R20 - volatile arm writes working copies only
// R21 - reset loads working copies from persistent
// R22 - guard with pin low locks first and second registers
// R23 - behaviour and reads use working copies
// R24 - reserved bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
module fsr_bank #(
   parameter int unsigned WRSR_CYC   = fsr_pkg::WRSR_CYC_DEF,
   parameter int unsigned PROG_CYC   = fsr_pkg::PROG_CYC_DEF,
   parameter int unsigned SERASE_CYC = fsr_pkg::SERASE_CYC_DEF,
   parameter int unsigned BERASE_CYC = fsr_pkg::BERASE_CYC_DEF,
   parameter int unsigned CERASE_CYC = fsr_pkg::CERASE_CYC_DEF
) (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       cs_n,
   input  wire logic       sclk,
   input  wire logic       mosi,
   input  wire logic       guard_n_lane_two,
   input  wire logic       pause_n_lane_three,
   output logic            miso,
   output logic            miso_oe_n,
   output logic            busy,
   output logic            write_arm_latch,
   output logic            paused_op_flag,
   output logic            four_lane_enable,
   output logic            pause_pin_active,
   output logic            reset_pin_active,
   output logic [1:0]      drive_strength,
   output logic            fast_clock_mode,
   output logic            array_op_start,
   output logic            array_op_reject
);
   import fsr_pkg::*;

   logic [4:0]  pin_s1_q, pin_s2_q;
   logic        sclk_d_q, cs_d_q;
   logic        cs_n_s, sclk_s, mosi_s, wp_n_s, hold_n_s;
   logic        held, hw_rst, sclk_rise, cs_rise, go;
   logic [7:0]  sh_q, sh_in, cmd_q, data1_q, data2_q, out_sh_q, rd_cmd, rd_val;
   logic [23:0] addr_q;
   logic [2:0]  bit_q, byte_q;
   logic        miso_q, oe_n_q, rd_act_q;
   logic        busy_q, wel_q, vwen_q, paused_q, rst_arm_q;
   logic [31:0] cnt_q, start_cnt;
   fsr_op_e     op_q;
   logic [5:0]  nv_sr1_q, vol_sr1_q;
   logic        nv_cmp_q, vol_cmp_q, nv_qe_q, vol_qe_q;
   logic [2:0]  nv_lb_q;
   logic        nv_hold_or_reset_select_q, vol_hold_or_reset_select_q, nv_hfm_q, vol_hfm_q;
   logic [1:0]  vol_drv_q;
   logic        pause_act_q, reset_act_q, start_q, reject_q;
   logic        acc, soft_rst, reset_all, wr_cmd, wr_any, guard_lock;
   logic        up1, up2, up3, nv_wr, arr_cmd, blocked, arr_start, arr_rej;
   logic        suspend_ok, resume_ok, prot_hit, prot_any;
   logic [7:0]  d2;

   // two-flop sampling of every pin
   always_ff @(posedge clk) begin
      if (srst) begin
         pin_s1_q <= PIN_IDLE;
         pin_s2_q <= PIN_IDLE;
         sclk_d_q <= 1'b0;
         cs_d_q   <= 1'b1;
      end else begin
         pin_s1_q <= {pause_n_lane_three, guard_n_lane_two, mosi, sclk, cs_n};
         pin_s2_q <= pin_s1_q;
         sclk_d_q <= pin_s2_q[PIN_SCLK];
         cs_d_q   <= pin_s2_q[PIN_CS];
      end
   end

   assign cs_n_s    = pin_s2_q[PIN_CS];
   assign sclk_s    = pin_s2_q[PIN_SCLK];
   assign mosi_s    = pin_s2_q[PIN_MOSI];
   assign wp_n_s    = pin_s2_q[PIN_WP];
   assign hold_n_s  = pin_s2_q[PIN_HOLD];
   assign held      = pause_act_q & !hold_n_s;                   // R5 R6
   assign hw_rst    = reset_act_q & !hold_n_s;                   // R5 R6
   assign sclk_rise = sclk_s & !sclk_d_q & !cs_n_s & !held;
   assign cs_rise   = cs_n_s & !cs_d_q;
   assign sh_in     = {sh_q[6:0], mosi_s};
   // whole bytes only, else the frame is dropped
   assign go        = cs_rise & (bit_q == 3'h0) & (byte_q != 3'h0) & !hw_rst;

   // frame shifter and byte capture
   always_ff @(posedge clk) begin
      if (srst || cs_n_s || hw_rst) begin
         bit_q  <= 3'h0;
         byte_q <= 3'h0;
         sh_q   <= BYTE_ZERO;
      end else if (sclk_rise) begin
         sh_q  <= sh_in;
         bit_q <= 3'(bit_q + 3'h1);
         if (bit_q == 3'h7 && byte_q != BYTES_MAX) begin
            byte_q <= 3'(byte_q + 3'h1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cmd_q   <= BYTE_ZERO;
         data1_q <= BYTE_ZERO;
         data2_q <= BYTE_ZERO;
         addr_q  <= 24'h000000;
      end else if (sclk_rise && bit_q == 3'h7) begin
         unique case (byte_q)
            3'h0: cmd_q <= sh_in;
            3'h1: begin
               data1_q       <= sh_in;
               addr_q[23:16] <= sh_in;
            end
            3'h2: begin
               data2_q      <= sh_in;
               addr_q[15:8] <= sh_in;
            end
            3'h3: addr_q[7:0] <= sh_in;
            default: ;
         endcase
      end
   end

   // read path: status value reloaded at each byte end
   assign rd_cmd = (byte_q == 3'h0) ? sh_in : cmd_q;
   always_comb begin
      // R23 R24
      unique case (rd_cmd)
         CMD_RDSR1: rd_val = {vol_sr1_q, wel_q, busy_q};
         CMD_RDSR2: rd_val = {paused_q, vol_cmp_q, nv_lb_q, 1'b0, vol_qe_q, 1'b0};
         CMD_RDSR3: rd_val = {vol_hold_or_reset_select_q, vol_drv_q, vol_hfm_q, 4'h0};
         default:   rd_val = BYTE_ZERO;
      endcase
   end

   // data leaves just after the rising edge the host sampled on
   always_ff @(posedge clk) begin
      if (srst) begin
         miso_q   <= 1'b0;
         out_sh_q <= BYTE_ZERO;
         rd_act_q <= 1'b0;
      end else if (cs_n_s || hw_rst) begin
         rd_act_q <= 1'b0;
      end else if (sclk_rise) begin
         if (bit_q == 3'h7 && (rd_cmd == CMD_RDSR1 || rd_cmd == CMD_RDSR2 || rd_cmd == CMD_RDSR3)) begin
            miso_q   <= rd_val[7];
            out_sh_q <= {rd_val[6:0], 1'b0};
            rd_act_q <= 1'b1;
         end else begin
            miso_q   <= out_sh_q[7];
            out_sh_q <= {out_sh_q[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         oe_n_q <= 1'b1;
      end else begin
         oe_n_q <= cs_n_s | held | !rd_act_q;
      end
   end

   // instruction decode at frame end
   assign acc        = go & !busy_q;                                        // R10
   assign soft_rst   = acc & (cmd_q == CMD_RST) & rst_arm_q;
   assign reset_all  = hw_rst | soft_rst;
   assign guard_lock = vol_sr1_q[SR1_GUARD - 2] & !wp_n_s & !vol_qe_q;      // R22 R5
   assign wr_cmd     = acc & !paused_q & (byte_q >= BYTES_WRSR)
                       & (cmd_q == CMD_WRSR1 || cmd_q == CMD_WRSR2 || cmd_q == CMD_WRSR3);
   assign wr_any     = wr_cmd & (wel_q | vwen_q);                           // R17
   assign nv_wr      = wel_q;                                               // R19
   assign up1        = wr_any & !guard_lock & (cmd_q == CMD_WRSR1);         // R14 R17 R22
   assign up2        = wr_any & !guard_lock
                       & ((cmd_q == CMD_WRSR2) | ((cmd_q == CMD_WRSR1) & (byte_q >= BYTES_WRSR2)));
   assign up3        = wr_any & (cmd_q == CMD_WRSR3);
   assign d2         = (cmd_q == CMD_WRSR2) ? data1_q : data2_q;
   assign arr_cmd    = acc & !paused_q &
                       (((cmd_q == CMD_PROG) & (byte_q >= BYTES_PROG)) |
                        ((cmd_q == CMD_SERASE || cmd_q == CMD_BERASE) & (byte_q >= BYTES_ERASE)) |
                        (cmd_q == CMD_CERASE));
   assign blocked    = (cmd_q == CMD_CERASE) ? prot_any : prot_hit;
   assign arr_start  = arr_cmd & wel_q & !blocked;                          // R15
   assign arr_rej    = arr_cmd & wel_q & blocked;                           // R15
   assign suspend_ok = go & (cmd_q == CMD_SUSPEND) & busy_q & (op_q == OP_ARRAY) & !paused_q;
   assign resume_ok  = acc & (cmd_q == CMD_RESUME) & paused_q;

   fsr_prot_chk #(
      .AW (ARRAY_AW)
   ) u_prot (
      .addr     (addr_q[ARRAY_AW-1:0]),
      .range    (vol_sr1_q[2:0]),
      .from_low (vol_sr1_q[SR1_TB - 2]),
      .granule  (vol_sr1_q[SR1_SEC - 2]),
      .invert   (vol_cmp_q),
      .hit      (prot_hit),
      .any      (prot_any)
   );

   always_comb begin
      unique case (cmd_q)
         CMD_PROG:   start_cnt = 32'(PROG_CYC);
         CMD_SERASE: start_cnt = 32'(SERASE_CYC);
         CMD_BERASE: start_cnt = 32'(BERASE_CYC);
         CMD_CERASE: start_cnt = 32'(CERASE_CYC);
         default:    start_cnt = 32'(WRSR_CYC);
      endcase
   end

   // busy timer and suspend
   always_ff @(posedge clk) begin
      if (srst || reset_all) begin
         busy_q   <= 1'b0;
         paused_q <= 1'b0;
         cnt_q    <= 32'h0;
         op_q     <= OP_IDLE;
      end else if (arr_start || (wr_any && nv_wr)) begin
         busy_q <= 1'b1;                                                    // R9
         cnt_q  <= start_cnt;
         op_q   <= arr_start ? OP_ARRAY : OP_WRSR;
      end else if (suspend_ok) begin
         busy_q   <= 1'b0;
         paused_q <= 1'b1;                                                  // R1
      end else if (resume_ok) begin
         busy_q   <= 1'b1;
         paused_q <= 1'b0;                                                  // R1
      end else if (busy_q) begin
         if (cnt_q <= 32'h1) begin
            busy_q <= 1'b0;                                                 // R11
            op_q   <= OP_IDLE;
         end else begin
            cnt_q <= cnt_q - 32'h1;
         end
      end
   end

   // write arm latches and reset arming
   always_ff @(posedge clk) begin
      if (srst || reset_all) begin
         wel_q     <= 1'b0;                                                 // R13
         vwen_q    <= 1'b0;
         rst_arm_q <= 1'b0;
      end else if (acc) begin
         rst_arm_q <= (cmd_q == CMD_RSTEN);
         vwen_q    <= (cmd_q == CMD_VWREN);
         if (cmd_q == CMD_WREN) begin
            wel_q <= 1'b1;                                                  // R12
         end else if (cmd_q == CMD_WRDI || wr_cmd || arr_cmd) begin
            wel_q <= 1'b0;                                                  // R13
         end
      end
   end

   // persistent copies
   always_ff @(posedge clk) begin
      if (srst) begin
         nv_sr1_q  <= SR1_CFG_RST;
         nv_cmp_q  <= 1'b0;
         nv_qe_q   <= 1'b0;
         nv_lb_q   <= LB_RST;
         nv_hold_or_reset_select_q <= 1'b0;
         nv_hfm_q  <= 1'b0;
      end else if (nv_wr) begin
         if (up1) begin
            nv_sr1_q <= data1_q[7:2];                                       // R19
         end
         if (up2) begin
            nv_cmp_q <= d2[SR2_CMP];
            nv_qe_q  <= d2[SR2_QE];
            nv_lb_q  <= nv_lb_q | d2[SR2_LB1 +: 3];                         // R3
         end
         if (up3) begin
            nv_hold_or_reset_select_q <= data1_q[SR3_HOLD_OR_RESET_SELECT];
            nv_hfm_q  <= data1_q[SR3_HFM];                                  // R8
         end
      end
   end

   // working copies
   always_ff @(posedge clk) begin
      if (srst) begin
         vol_sr1_q  <= SR1_CFG_RST;
         vol_cmp_q  <= 1'b0;
         vol_qe_q   <= 1'b0;
         vol_hold_or_reset_select_q <= 1'b0;
         vol_hfm_q  <= 1'b0;
         vol_drv_q  <= DRV_RST;
      end else if (reset_all) begin
         vol_sr1_q  <= nv_sr1_q;                                            // R21
         vol_cmp_q  <= nv_cmp_q;
         vol_qe_q   <= nv_qe_q;
         vol_hold_or_reset_select_q <= nv_hold_or_reset_select_q;
         vol_hfm_q  <= nv_hfm_q;
         vol_drv_q  <= DRV_RST;
      end else begin
         if (up1) begin
            vol_sr1_q <= data1_q[7:2];                                      // R20
         end
         if (up2) begin
            vol_cmp_q <= d2[SR2_CMP];                                       // R2
            vol_qe_q  <= d2[SR2_QE];                                        // R5
         end
         if (up3) begin
            vol_hold_or_reset_select_q <= data1_q[SR3_HOLD_OR_RESET_SELECT];                                // R6
            vol_hfm_q  <= data1_q[SR3_HFM];                                 // R8
            vol_drv_q  <= data1_q[SR3_DRV +: 2];                            // R7
         end
      end
   end

   // pin function select and op pulses
   always_ff @(posedge clk) begin
      if (srst) begin
         pause_act_q <= 1'b1;
         reset_act_q <= 1'b0;
         start_q     <= 1'b0;
         reject_q    <= 1'b0;
      end else begin
         pause_act_q <= !vol_qe_q & !vol_hold_or_reset_select_q;                            // R5 R6
         reset_act_q <= !vol_qe_q & vol_hold_or_reset_select_q;                             // R5 R6
         start_q     <= arr_start;
         reject_q    <= arr_rej;
      end
   end

   assign miso             = miso_q;
   assign miso_oe_n        = oe_n_q;
   assign busy             = busy_q;
   assign write_arm_latch  = wel_q;
   assign paused_op_flag   = paused_q;
   assign four_lane_enable = vol_qe_q;
   assign pause_pin_active = pause_act_q;
   assign reset_pin_active = reset_act_q;
   assign drive_strength   = vol_drv_q;
   assign fast_clock_mode  = vol_hfm_q;
   assign array_op_start   = start_q;
   assign array_op_reject  = reject_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence seq_acc(logic [7:0] c);
      acc && cmd_q == c;
   endsequence

   sequence seq_nv_write;
      wr_any && wel_q && !reset_all;
   endsequence

   pause_sets_a: assert property ($rose(paused_q) |-> $past(suspend_ok)) // R1
      else $error("suspend flag rose without suspend");
   otp_sticky_a: assert property (##1 ((nv_lb_q & $past(nv_lb_q)) == $past(nv_lb_q))) // R3
      else $error("lock bit cleared");
   busy_start_a: assert property (seq_nv_write |=> busy_q && cnt_q == 32'(WRSR_CYC)) // R9
      else $error("status write did not start busy");
   busy_ignore_a: assert property (busy_q && go && cmd_q == CMD_WREN && !hw_rst |=> $stable(wel_q)) // R10
      else $error("instruction taken while busy");
   busy_end_a: assert property (busy_q && cnt_q == 32'h1 && !go && !hw_rst |=> !busy_q) // R11
      else $error("busy did not clear at end");
   wel_set_a: assert property (seq_acc(CMD_WREN) ##0 !reset_all |=> wel_q [*2]) // R12
      else $error("write enable not latched");
   wel_clear_a: assert property (seq_acc(CMD_WRDI) or (arr_cmd && !reset_all) |=> !wel_q) // R13
      else $error("arm latch not cleared");
   reject_a: assert property (arr_rej |=> !busy_q && reject_q && !start_q) // R15
      else $error("protected array op not refused");
   guard_a: assert property (wr_cmd && guard_lock && cmd_q != CMD_WRSR3 && !reset_all // R22
                             |=> $stable(vol_sr1_q) && $stable(vol_qe_q))
      else $error("guarded register changed");
   vol_only_a: assert property (wr_any && !wel_q |=> $stable(nv_sr1_q) && $stable(nv_lb_q) // R20
                                && !busy_q)
      else $error("volatile write touched persistent copy");
   lane_pins_a: assert property (vol_qe_q [*2] |-> !pause_pin_active && !reset_pin_active) // R5
      else $error("pin function active in four-lane mode");
   reload_a: assert property (soft_rst |=> vol_sr1_q == $past(nv_sr1_q) && !wel_q) // R21
      else $error("reset did not reload working copy");
endmodule
`default_nettype wire

/* File: testbench/fsr_host.sv */
// spi host model that issues status register frames
`timescale 1ns/1ps
`default_nettype none
module fsr_host (
   input  wire logic clk,
   input  wire logic miso,
   output logic      cs_n,
   output logic      sclk,
   output logic      mosi
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end
   // mode 0, msb first, whole bytes, clock still between frames
   task automatic frame(input logic [31:0] d, input int nb, output logic [7:0] rx);
      @(posedge clk) cs_n <= 1'b0;
      for (int i = 0; i < nb * 8; i++) begin
         mosi <= d[31-i];
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         rx = {rx[6:0], miso};
         repeat (4) @(posedge clk);
         sclk <= 1'b0;
      end
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      mosi <= ~mosi;
      repeat (8) @(posedge clk);
   endtask
endmodule
`default_nettype wire

/* File: testbench/tb_flash_status_register_bank.sv */
// self-checking bench for the flash status register bank
`timescale 1ns/1ps
`default_nettype none
module tb_flash_status_register_bank;
   import fsr_pkg::*;
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected %0t got %h exp %h", $time, g, e); end end
   logic        clk = 1'b0, srst = 1'b1, gp_n = 1'b1, hp_n = 1'b1;
   logic        cs_n, sclk, mosi, miso, oe_n, busy, wal, pof, qe, ppa, rpa, fcm, go, rej;
   logic [1:0]  drv;
   logic [7:0]  v, e1, lk;
   logic [20:0] ad;
   logic [23:0] a;
   int          err_total = 0, num_checks = 0, n_go = 0, n_rej = 0, n_oe = 0, g0, r0;
   always #10 clk = ~clk;
   fsr_host i_fsr_host (.clk(clk), .miso(miso), .cs_n(cs_n), .sclk(sclk), .mosi(mosi));
   fsr_bank #(.WRSR_CYC(200), .PROG_CYC(100), .SERASE_CYC(100), .BERASE_CYC(100), .CERASE_CYC(100))
   i_fsr_bank (.clk(clk), .srst(srst), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
      .guard_n_lane_two(gp_n), .pause_n_lane_three(hp_n), .miso(miso), .miso_oe_n(oe_n),
      .busy(busy), .write_arm_latch(wal), .paused_op_flag(pof), .four_lane_enable(qe),
      .pause_pin_active(ppa), .reset_pin_active(rpa), .drive_strength(drv),
      .fast_clock_mode(fcm), .array_op_start(go), .array_op_reject(rej));
   always @(posedge clk) begin
      if (go === 1'b1) n_go++;
      if (rej === 1'b1) n_rej++;
      if (oe_n === 1'b0) n_oe++;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic cmd(input logic [31:0] d, input int nb);
      logic [7:0] r;
      i_fsr_host.frame(d, nb, r);
   endtask
   task automatic rd(input logic [7:0] c);
      int o0;
      o0 = n_oe;
      i_fsr_host.frame({c, 24'h0}, 2, v);
      `CHK({oe_n, n_oe > o0}, 2'b11)
   endtask
   // arm first, then the write frame
   task automatic wr(input logic [7:0] en, input logic [31:0] d, input int nb);
      cmd({en, 24'h0}, 1);
      cmd(d, nb);
   endtask
   task automatic idle();
      for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(posedge clk);
      if (busy !== 1'b0) begin
         err_total++;
         tally_and_finish();
      end
   endtask
   task automatic regs(input logic [7:0] x1, x2, x3);
      rd(CMD_RDSR1);
      `CHK(v, x1)
      rd(CMD_RDSR2);
      `CHK(v, x2)
      rd(CMD_RDSR3);
      `CHK(v, x3)
   endtask
   // protected-or-not for an address, from the range, end, granule and invert fields
   function automatic logic prot(input logic [7:0] s1, input logic cmp, input logic [20:0] x);
      logic [21:0] sz;
      if (s1[4:2] == 3'h0) sz = 22'h0;
      else if (s1[6]) sz = (s1[4:2] >= 3'h5) ? 22'h8000 : 22'h1000 << (s1[4:2] - 3'h1);
      else sz = (s1[4:2] >= 3'h6) ? 22'h200000 : 22'h10000 << (s1[4:2] - 3'h1);
      return cmp ^ (s1[5] ? ({1'b0, x} < sz) : ({1'b0, x} >= 22'h200000 - sz));
   endfunction
   initial begin
      void'($urandom(32'hfd284120));
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      repeat (4) @(posedge clk);
      regs(8'h00, 8'h00, 8'h00);
      `CHK({busy, wal, pof, qe, ppa, rpa, drv, fcm}, 9'h010)
      cmd({CMD_WREN, 24'h0}, 1);
      `CHK(wal, 1'b1)
      cmd({CMD_WRDI, 24'h0}, 1);
      `CHK(wal, 1'b0)
      $display("test defaults done");
      repeat (4) begin
         a = 24'($urandom);
         wr(CMD_VWREN, {CMD_WRSR1, a[15:8], a[7:0], 8'h00}, 3);
         wr(CMD_VWREN, {CMD_WRSR3, a[23:16], 16'h0}, 2);
         regs(a[15:8] & 8'hfc, a[7:0] & 8'h42, a[23:16] & 8'hf0);
         `CHK({wal, busy, qe, ppa, rpa, drv, fcm}, {2'b00, a[1], ~a[1] & ~a[23], ~a[1] & a[23], a[22:20]})
      end
      $display("test volatile done");
      // third register keeps the last volatile value until the reset reloads its persistent zero
      a[15:0] = 16'($urandom);
      lk = a[7:0] & 8'h38;
      wr(CMD_WREN, {CMD_WRSR1, a[15:8], a[7:0], 8'h00}, 3);
      `CHK(busy, 1'b1)
      cmd({CMD_WREN, 24'h0}, 1);
      rd(CMD_RDSR1);
      `CHK(v[1:0], 2'b01)
      idle();
      regs(a[15:8] & 8'hfc, a[7:0] & 8'h7a, a[23:16] & 8'hf0);
      wr(CMD_VWREN, {CMD_WRSR2, 24'h0}, 2);
      rd(CMD_RDSR2);
      `CHK(v, lk)
      cmd({CMD_RSTEN, 24'h0}, 1);
      cmd({CMD_RST, 24'h0}, 1);
      regs(a[15:8] & 8'hfc, a[7:0] & 8'h7a, 8'h00);
      wr(CMD_VWREN, {CMD_WRSR1, 8'h80, 16'h0}, 3);
      gp_n <= 1'b0;
      wr(CMD_VWREN, {CMD_WRSR1, 8'h1c, 8'h42, 8'h00}, 3);
      regs(8'h80, lk, 8'h00);
      gp_n <= 1'b1;
      $display("test persistent done");
      for (int i = 0; i < 10; i++) begin
         a = 24'($urandom);
         ad = (i < 2) ? {21{i[0]}} : 21'($urandom);
         e1 = a[23:16] & 8'h7c;
         wr(CMD_VWREN, {CMD_WRSR1, e1, 1'b0, a[0], 6'h0, 8'h00}, 3);
         g0 = n_go;
         r0 = n_rej;
         wr(CMD_WREN, {CMD_SERASE, 3'h0, ad}, 4);
         `CHK({n_go - g0 == 1, n_rej - r0 == 1}, {~prot(e1, a[0], ad), prot(e1, a[0], ad)})
         idle();
      end
      $display("test protection done");
      wr(CMD_VWREN, {CMD_WRSR1, 24'h0}, 3);
      wr(CMD_WREN, {CMD_SERASE, 24'h0}, 4);
      cmd({CMD_SUSPEND, 24'h0}, 1);
      rd(CMD_RDSR2);
      `CHK({v[7], pof}, 2'b11)
      cmd({CMD_RESUME, 24'h0}, 1);
      idle();
      `CHK(pof, 1'b0)
      $display("test suspend done");
      wr(CMD_VWREN, {CMD_WRSR3, 8'hc0, 16'h0}, 2);
      cmd({CMD_WREN, 24'h0}, 1);
      `CHK({ppa, rpa, wal, drv}, 5'b01110)
      hp_n <= 1'b0;
      repeat (4) @(posedge clk);
      hp_n <= 1'b1;
      repeat (8) @(posedge clk);
      `CHK({ppa, rpa, wal, drv}, 5'b10000)
      $display("test pin reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
